// *** bench/fdrl_drive_model.sv ***
// Drive stand-in: media sense lines with pull-ups
`timescale 1ns/1ps
module fdrl_drive_model
(
	// Bench control
	input  wire       present,
	input  wire [1:0] media,
	// Drive lines
	input  wire [1:0] motor_enable_n,
	output wire [1:0] media_sense_in
);
	// Pull-ups win when no medium is fitted
	assign media_sense_in = present ? media : 2'h3;
endmodule

// *** bench/fdrl_props.sv ***
// Port assertions for the drive-line block
`timescale 1ns/1ps
module fdrl_props
(
	// Clock and resets
	input wire       REF_CLK,
	input wire       RST,
	input wire       CONTROLLER_RESET_IN,
	// Register port
	input wire [7:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR,
	input wire       RD,
	input wire [7:0] RDATA,
	// Drive side
	input wire [1:0] MEDIA_SENSE_IN,
	input wire [1:0] MOTOR_ENABLE_N,
	input wire       DRIVE_ENABLE,
	input wire [1:0] DRIVE_SEL,
	input wire       SEQ_READY
);
	reg  [7:0] doc_r;
	reg        enc_r;
	reg        sense_r;
	wire       cr  = CONTROLLER_RESET_IN;
	wire [1:0] enc = doc_r[4 + doc_r[1:0]] ? ~doc_r[1:0] : 2'h3;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// Shadow copy so output checks need no read-back
	always @(posedge REF_CLK)
	begin
		if (RST || cr)
		begin
			doc_r  <= 8'h00;
			enc_r  <= 1'b0;
			sense_r <= 1'b0;
		end
		else if (WR && ADDR == 8'h02)
			doc_r  <= WDATA;
		else if (WR && ADDR == 8'hf0)
		begin
			enc_r  <= WDATA[7];
			sense_r <= WDATA[6];
		end
	end
	property p_rm; cr |=> MOTOR_ENABLE_N == 2'h3; endproperty
	a_rm: assert property (p_rm) else $error("motor on after reset");
	property p_re; cr |=> !DRIVE_ENABLE && DRIVE_SEL == 2'h0; endproperty
	a_re: assert property (p_re) else $error("drive lines after reset");
	property p_rr; cr |=> !SEQ_READY; endproperty
	a_rr: assert property (p_rr) else $error("sequencer not idle");
	property p_ds; WR && ADDR == 8'h02 && !cr ##1 !cr |=> DRIVE_SEL == $past(WDATA[1:0], 2); endproperty
	a_ds: assert property (p_ds) else $error("select not from control");
	property p_md; !enc_r && !cr ##1 !cr |-> MOTOR_ENABLE_N == ~$past(doc_r[5:4]); endproperty
	a_md: assert property (p_md) else $error("direct motor wrong");
	property p_me; enc_r && !cr ##1 !cr |-> MOTOR_ENABLE_N == $past(enc); endproperty
	a_me: assert property (p_me) else $error("encoded motor wrong");
	property p_rd; RD && ADDR == 8'h02 && !cr |=> RDATA == $past(doc_r); endproperty
	a_rd: assert property (p_rd) else $error("control readback wrong");
	// The sensed bits lag the enable by one flop, so the enable must have been off twice
	property p_ms; RD && ADDR == 8'h14 && !sense_r && !$past(sense_r) && !cr
		|=> RDATA[3:2] == 2'h0; endproperty
	a_ms: assert property (p_ms) else $error("media seen while off");
endmodule
bind fdrl_top fdrl_props u_props (.REF_CLK, .RST, .CONTROLLER_RESET_IN, .ADDR, .WDATA, .WR,
	.RD, .RDATA, .MEDIA_SENSE_IN, .MOTOR_ENABLE_N, .DRIVE_ENABLE, .DRIVE_SEL, .SEQ_READY);

// *** bench/fdrl_tb.sv ***
// Self-checking bench for the drive-line block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module floppy_reset_and_drive_lines_test;
	reg        clk = 0;
	reg        rst = 1;
	reg        cr = 0;
	reg        wr = 0;
	reg        rd = 0;
	reg  [7:0] addr = 0;
	reg  [7:0] wdata = 0;
	reg        present = 0;
	reg  [1:0] media = 0;
	wire [7:0] rdata;
	wire [1:0] msen;
	wire [1:0] mot;
	wire [1:0] sel;
	wire       ena;
	wire       rdy;
	int        checked = 0;
	int        n_errors = 0;
	fdrl_top dut (.REF_CLK(clk), .RST(rst), .CONTROLLER_RESET_IN(cr), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .MEDIA_SENSE_IN(msen),
		.MOTOR_ENABLE_N(mot), .DRIVE_ENABLE(ena), .DRIVE_SEL(sel), .SEQ_READY(rdy));
	fdrl_drive_model drv (.present(present), .media(media), .motor_enable_n(mot),
		.media_sense_in(msen));
	initial
	begin
		forever #10 clk = ~clk;
	end
	task w(input [7:0] a, input [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Write, then let the output flop take the new value
	task wc(input [7:0] a, input [7:0] d);
		w(a, d);
		@(posedge clk);
		#1;
	endtask
	task r(input [7:0] a, input [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task t_direct;
		r(8'h13, 8'hcf);
		wc(8'h02, 8'h36);
		`CHK("mot", 2'h0, mot)
		`CHK("sel", 2'h2, sel)
		`CHK("ena", 1'b1, ena)
		wc(8'h02, 8'h10);
		`CHK("mot", 2'h2, mot)
		r(8'h02, 8'h10);
		r(8'h99, 8'h00);
	endtask
	task t_encoded;
		int i;
		wc(8'hf0, 8'h80);
		for (i = 0; i < 4; i++)
		begin
			wc(8'h02, (8'h10 << i) | i);
			`CHK("enc", ~i[1:0], mot)
		end
		wc(8'h02, 8'h23);
		`CHK("enc", 2'h3, mot)
		wc(8'hf0, 8'h00);
	endtask
	task t_media;
		@(posedge clk);
		present <= 1'b1;
		media <= 2'h2;
		wc(8'hf0, 8'h40);
		r(8'h14, 8'h08);
		wc(8'hf0, 8'h00);
		r(8'h14, 8'h00);
	endtask
	task t_reset;
		int i;
		w(8'h13, 8'h5a);
		w(8'h10, 8'h77);
		w(8'h11, 8'h01);
		w(8'h12, 8'h01);
		w(8'h04, 8'h11);
		w(8'h07, 8'h03);
		w(8'h02, 8'h36);
		w(8'hf0, 8'h40);
		// Abort in mid spin-up, then spin up again and time the settle
		w(8'h15, 8'h01);
		r(8'h14, 8'h09);
		w(8'h15, 8'h02);
		r(8'h14, 8'h08);
		w(8'h15, 8'h01);
		for (i = 0; i < 1100 && rdy !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		`CHK("spin", 1001, i)
		`CHK("rdy", 1'b1, rdy)
		if (rdy !== 1'b1)
			return;
		@(posedge clk);
		cr <= 1'b1;
		@(posedge clk);
		cr <= 1'b0;
		#1;
		`CHK("mot", 2'h3, mot)
		`CHK("ena", 1'b0, ena)
		`CHK("sel", 2'h0, sel)
		`CHK("rdy", 1'b0, rdy)
		r(8'h02, 8'h00);
		r(8'h04, 8'h00);
		r(8'h07, 8'h00);
		r(8'h10, 8'h00);
		r(8'h11, 8'h20);
		r(8'h12, 8'h00);
		r(8'h13, 8'h5a);
		r(8'hf0, 8'h20);
		r(8'h14, 8'h00);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_direct();
		t_encoded();
		t_media();
		t_reset();
		wrap_up();
	end
endmodule

// *** logic/fdrl_motor_enc.v ***
// Motor enable encoder: direct two-drive mode or encoded four-drive mode
`timescale 1ns/1ps
`include "fdrl_regs.vh"

module fdrl_motor_enc
(
	// Control inputs
	input  wire       enc_mode,
	input  wire [3:0] motor_bits,
	input  wire [1:0] drive_sel,
	// Active-low motor lines
	output reg  [1:0] motor_n
);

	always @*
	begin
		motor_n = 2'h3;
		if (enc_mode)
		begin
			// RL9: four-drive encoding
			// Inverted selected drive number on the lines when its motor bit is on, else both high
			if (motor_bits[drive_sel])
				motor_n = ~drive_sel;
			else
				motor_n = 2'h3;
		end
		else
		begin
			// RL11: direct inverted bits
			motor_n = ~motor_bits[1:0];
		end
	end

endmodule

// *** logic/fdrl_regs.vh ***
// Register offsets, field positions, reset values and fixed codes for the drive-line block
`ifndef FDRL_REGS_VH
`define FDRL_REGS_VH

// Register offsets (8-bit address space)
`define FDRL_ADDR_DOC      8'h02
`define FDRL_ADDR_DRS      8'h04
`define FDRL_ADDR_CFGCTL   8'h07
`define FDRL_ADDR_FCFG     8'hf0
`define FDRL_ADDR_SETUP    8'h10
`define FDRL_ADDR_PARAMS   8'h11
`define FDRL_ADDR_FREEZE   8'h12
`define FDRL_ADDR_TIMING   8'h13
`define FDRL_ADDR_STATUS   8'h14
`define FDRL_ADDR_CMD      8'h15

// Drive output control fields
`define FDRL_DOC_MOT_HI    7
`define FDRL_DOC_MOT_LO    4
`define FDRL_DOC_ENA_BIT   2
`define FDRL_DOC_SEL_HI    1
`define FDRL_DOC_SEL_LO    0

// Floppy configuration fields
`define FDRL_FCFG_ENC_BIT  7
`define FDRL_FCFG_SENSE_BIT 6

// Reset values
`define FDRL_RST_DOC       8'h00
`define FDRL_RST_DRS       8'h00
`define FDRL_RST_CFGCTL    8'h00
`define FDRL_RST_FCFG      8'h20
`define FDRL_RST_SETUP     8'h00
`define FDRL_RST_PARAMS    8'h20
`define FDRL_RST_FREEZE    8'h00
`define FDRL_RST_TIMING    8'hcf

// Command codes written to the command register
`define FDRL_CMD_SPINUP    8'h01
`define FDRL_CMD_ABORT     8'h02

// Spin-up settle time: 20 us at the 50 MHz reference clock
`define FDRL_SPIN_CYC      16'h03e8

`endif

// *** logic/fdrl_top.v ***
// Floppy controller reset and drive-side control lines with register port
// Operation
// RL1: Controller reset returns the internal sequencer to its idle state.
// RL2: While controller reset is high every drive-side output sits at its inactive level.
// RL3: Controller reset clears the drive output control, data rate and configuration control registers.
// RL4: Controller reset restores the setup, setup-parameter and parameter-freeze values to defaults.
// RL5: Controller reset leaves the drive timing parameters untouched.
// RL6: Controller reset loads the floppy configuration register with its default value.
// RL7: The motor enable lines are driven from bits 7 to 4 of the drive output control register.
// RL8: The motor enable lines are active low, low meaning motor on.
// RL9: With configuration bit 7 set the motor lines carry an encoded value serving four drives.
// RL10: Media sense inputs are only used when configuration bit 6 is one.
// RL11: With encoding off each motor line is the inverse of its own motor bit.
`timescale 1ns/1ps
`include "fdrl_regs.vh"

module fdrl_top
(
	// Clock and system reset
	input  wire       REF_CLK,
	input  wire       RST,
	// Controller reset from the host bus
	input  wire       CONTROLLER_RESET_IN,
	// Register port
	input  wire [7:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	// Drive side
	input  wire [1:0] MEDIA_SENSE_IN,
	output reg  [1:0] MOTOR_ENABLE_N,
	output reg        DRIVE_ENABLE,
	output reg  [1:0] DRIVE_SEL,
	output reg        SEQ_READY
);

	reg  [7:0]  doc_r;
	reg  [7:0]  drs_r;
	reg  [7:0]  cfgctl_r;
	reg  [7:0]  fcfg_r;
	reg  [7:0]  setup_r;
	reg  [7:0]  params_r;
	reg  [7:0]  freeze_r;
	reg  [7:0]  timing_r;
	reg  [1:0]  media_r;
	reg  [1:0]  state_r;
	reg  [1:0]  state_nxt;
	reg  [15:0] cnt_r;
	reg  [15:0] cnt_nxt;
	wire [1:0]  motor_n;
	wire        rst_any;
	wire        cmd_wr;

	localparam [15:0] SPIN_CYC = `FDRL_SPIN_CYC;
	// Sequencer states
	localparam [1:0]  ST_IDLE  = 2'h0;
	localparam [1:0]  ST_SPIN  = 2'h1;
	localparam [1:0]  ST_READY = 2'h2;

	// Decode helper used by every register write and the read mux
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	assign rst_any = RST | CONTROLLER_RESET_IN;
	assign cmd_wr  = WR & hit(ADDR, `FDRL_ADDR_CMD);

	// RL3: clear control registers
	always @(posedge REF_CLK)
	begin
		if (rst_any)
		begin
			doc_r <= `FDRL_RST_DOC;
			drs_r <= `FDRL_RST_DRS;
			cfgctl_r <= `FDRL_RST_CFGCTL;
		end
		else if (WR)
		begin
			if (hit(ADDR, `FDRL_ADDR_DOC))
				doc_r <= WDATA;
			if (hit(ADDR, `FDRL_ADDR_DRS))
				drs_r <= WDATA;
			if (hit(ADDR, `FDRL_ADDR_CFGCTL))
				cfgctl_r <= WDATA;
		end
	end

	// RL4: restore setup defaults
	// RL6: configuration defaults
	always @(posedge REF_CLK)
	begin
		if (rst_any)
		begin
			setup_r  <= `FDRL_RST_SETUP;
			params_r <= `FDRL_RST_PARAMS;
			freeze_r <= `FDRL_RST_FREEZE;
			fcfg_r   <= `FDRL_RST_FCFG;
		end
		else if (WR)
		begin
			if (hit(ADDR, `FDRL_ADDR_SETUP))
				setup_r <= WDATA;
			if (hit(ADDR, `FDRL_ADDR_PARAMS))
				params_r <= WDATA;
			if (hit(ADDR, `FDRL_ADDR_FREEZE))
				freeze_r <= WDATA;
			if (hit(ADDR, `FDRL_ADDR_FCFG))
				fcfg_r <= WDATA;
		end
	end

	// RL5: timing survives controller reset
	// Only the system reset may touch it, so drive timing is kept across a bus reset
	always @(posedge REF_CLK)
	begin
		if (RST)
			timing_r <= `FDRL_RST_TIMING;
		else if (WR && hit(ADDR, `FDRL_ADDR_TIMING))
			timing_r <= WDATA;
	end

	// RL10: media sense gating
	always @(posedge REF_CLK)
	begin
		if (rst_any)
			media_r <= 2'h0;
		else if (fcfg_r[`FDRL_FCFG_SENSE_BIT])
			media_r <= MEDIA_SENSE_IN;
		else
			media_r <= 2'h0;
	end

	// Spin-up sequencer: settle time after a spin-up command before drive is ready
	always @*
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			ST_IDLE:
			begin
				cnt_nxt = 16'h0000;
				if (cmd_wr && WDATA == `FDRL_CMD_SPINUP)
					state_nxt = ST_SPIN;
			end
			ST_SPIN:
			begin
				if (cmd_wr && WDATA == `FDRL_CMD_ABORT)
					state_nxt = ST_IDLE;
				else if (cnt_r == SPIN_CYC - 16'h0001)
					state_nxt = ST_READY;
				else
					cnt_nxt = cnt_r + 16'h0001;
			end
			ST_READY:
			begin
				if (cmd_wr && WDATA == `FDRL_CMD_ABORT)
					state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// RL1: reset to idle
	always @(posedge REF_CLK)
	begin
		if (rst_any)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= 16'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// RL7: motor bits feed encoder
	fdrl_motor_enc u_enc
	(
		.enc_mode   (fcfg_r[`FDRL_FCFG_ENC_BIT]),
		.motor_bits (doc_r[`FDRL_DOC_MOT_HI:`FDRL_DOC_MOT_LO]),
		.drive_sel  (doc_r[`FDRL_DOC_SEL_HI:`FDRL_DOC_SEL_LO]),
		.motor_n    (motor_n)
	);

	// RL2: drive outputs inactive in reset
	// RL8: active-low motor lines
	// Held off directly from the reset input so lines go idle in the same edge
	always @(posedge REF_CLK)
	begin
		if (rst_any)
		begin
			MOTOR_ENABLE_N <= 2'h3;
			DRIVE_ENABLE   <= 1'b0;
			DRIVE_SEL      <= 2'h0;
			SEQ_READY      <= 1'b0;
		end
		else
		begin
			MOTOR_ENABLE_N <= motor_n;
			DRIVE_ENABLE   <= doc_r[`FDRL_DOC_ENA_BIT];
			DRIVE_SEL      <= doc_r[`FDRL_DOC_SEL_HI:`FDRL_DOC_SEL_LO];
			SEQ_READY      <= (state_r == ST_READY);
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always @(posedge REF_CLK)
	begin
		if (RST)
			RDATA <= 8'h00;
		else if (!RD)
			RDATA <= 8'h00;
		else if (hit(ADDR, `FDRL_ADDR_DOC))
			RDATA <= doc_r;
		else if (hit(ADDR, `FDRL_ADDR_DRS))
			RDATA <= drs_r;
		else if (hit(ADDR, `FDRL_ADDR_CFGCTL))
			RDATA <= cfgctl_r;
		else if (hit(ADDR, `FDRL_ADDR_FCFG))
			RDATA <= fcfg_r;
		else if (hit(ADDR, `FDRL_ADDR_SETUP))
			RDATA <= setup_r;
		else if (hit(ADDR, `FDRL_ADDR_PARAMS))
			RDATA <= params_r;
		else if (hit(ADDR, `FDRL_ADDR_FREEZE))
			RDATA <= freeze_r;
		else if (hit(ADDR, `FDRL_ADDR_TIMING))
			RDATA <= timing_r;
		else if (hit(ADDR, `FDRL_ADDR_STATUS))
			RDATA <= {4'h0, media_r, state_r};
		else
			RDATA <= 8'h00;
	end

endmodule
